// ==== rdl_defines.svh ====
`ifndef RDL_DEFINES_SVH
`define RDL_DEFINES_SVH
// Functional notes
// - Frame opens with G or N
// - Space, six weight digits, space follow
// - Two unit characters then carriage return
// - Plain modes end with one line feed
// - Annunciator modes add eight bytes, CR, LF
// - Host resends frame every update period
// - Custom mode sends edited format bytes instead
// - Plain-mode remote shows only weight
// - Key commands only in keypad modes
// - Byte 2: net, gross, motion, zero, LED1, comma
// - Split annunciator lit only when both set
// - Byte 1 LED0/comma; bytes 4,6 comma/tare flag
// - Byte 3: outputs, print, tare, comma 3
// - Byte 5: peak/count, units, comma 5
// - Bytes 7,8: target bars in bits 6..1
// - Remote sends Z, T, P plus LF
// - S, U, F keys sent, host acts alike
// - Remote shows dashes while frames missing
// - Loss timeout between five and ten seconds
// - Non-keypad remote ignores keys, shows frames

// Characters
`define RDL_CH_G 8'h47
`define RDL_CH_N 8'h4E
`define RDL_CH_SP 8'h20
`define RDL_CH_CR 8'h0D
`define RDL_CH_LF 8'h0A
`define RDL_CH_0 8'h30
// Key letters, index order Z S T P U F
`define RDL_KEYS {8'h46, 8'h55, 8'h50, 8'h54, 8'h53, 8'h5A}
// Frame byte positions and lengths
`define RDL_IX_SP1 5'h01
`define RDL_IX_DIG 5'h02
`define RDL_IX_SP2 5'h08
`define RDL_IX_UNIT 5'h09
`define RDL_IX_CR1 5'h0B
`define RDL_IX_ANN 5'h0C
`define RDL_IX_CR2 5'h14
`define RDL_LEN_PLAIN 5'h0D
`define RDL_LEN_ANN 5'h16
// Used annunciator bits, byte 1 in bits 7:0
`define RDL_ANN_MASK 64'h7E7E_0197_41FF_FF81
// Register offsets
`define RDL_REG_CTRL 8'h00
`define RDL_REG_WEIGHT 8'h04
`define RDL_REG_UNIT 8'h08
`define RDL_REG_ANN_LO 8'h0C
`define RDL_REG_ANN_HI 8'h10
`define RDL_REG_PERIOD 8'h14
`define RDL_REG_KEYS 8'h18
`define RDL_REG_FMT 8'h20
// Control fields
`define RDL_CTRL_NET 4
`define RDL_CTRL_BUSY 16
// Timing
`define RDL_CLK_KHZ 125000
`define RDL_UPD_MS 10
`define RDL_UPD_CYC (`RDL_UPD_MS * `RDL_CLK_KHZ)
`define RDL_TMO_MS 8000
`define RDL_TMO_CYC (`RDL_TMO_MS * `RDL_CLK_KHZ)
`endif

// ==== rdl_host.sv ====
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`include "rdl_defines.svh"
module rdl_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [5:0] key_pulse,
  rdl_link_if.host_end link
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [11:0] ctrl_q;
  logic [23:0] weight_q;
  logic [15:0] unit_q;
  logic [63:0] ann_q;
  logic [31:0] period_q;
  logic [5:0] keys_q;
  logic [7:0] fmt_q [0:15];
  logic wr;
  logic busy;
  logic [5:0] key_set;

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // Bus answer one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read data, unmapped reads zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        `RDL_REG_CTRL: wb_dat_o <= {15'h0000, busy, 4'h0, ctrl_q};
        `RDL_REG_WEIGHT: wb_dat_o <= {8'h00, weight_q};
        `RDL_REG_UNIT: wb_dat_o <= {16'h0000, unit_q};
        `RDL_REG_ANN_LO: wb_dat_o <= ann_q[31:0];
        `RDL_REG_ANN_HI: wb_dat_o <= ann_q[63:32];
        `RDL_REG_PERIOD: wb_dat_o <= period_q;
        `RDL_REG_KEYS: wb_dat_o <= {26'h000_0000, keys_q};
        default: begin
          if (wb_adr_i[7:4] == `RDL_REG_FMT >> 4 && wb_adr_i[5]) begin
            wb_dat_o <= {fmt_q[{wb_adr_i[3:2], 2'h3}],
              fmt_q[{wb_adr_i[3:2], 2'h2}],
              fmt_q[{wb_adr_i[3:2], 2'h1}], fmt_q[{wb_adr_i[3:2], 2'h0}]};
          end else begin
            wb_dat_o <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // Writable control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= 12'h000;
      weight_q <= 24'h00_0000;
      unit_q <= 16'h0000;
      ann_q <= 64'h0000_0000_0000_0000;
      period_q <= 32'(`RDL_UPD_CYC);
    end else if (wr) begin
      case (wb_adr_i)
        `RDL_REG_CTRL: ctrl_q <= 12'(merge({20'h0, ctrl_q}, wb_dat_i,
          wb_sel_i));
        `RDL_REG_WEIGHT: weight_q <= 24'(merge({8'h0, weight_q},
          wb_dat_i, wb_sel_i));
        `RDL_REG_UNIT: unit_q <= 16'(merge({16'h0, unit_q}, wb_dat_i,
          wb_sel_i));
        `RDL_REG_ANN_LO: ann_q[31:0] <= merge(ann_q[31:0], wb_dat_i,
          wb_sel_i) & 32'(`RDL_ANN_MASK);
        `RDL_REG_ANN_HI: ann_q[63:32] <= merge(ann_q[63:32], wb_dat_i,
          wb_sel_i) & 32'(`RDL_ANN_MASK >> 32);
        `RDL_REG_PERIOD: period_q <= merge(period_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Custom format bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        fmt_q[i] <= 8'h00;
      end
    end else if (wr && wb_adr_i[7:4] >= 4'h2 && wb_adr_i[7:4] <= 4'h2) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          fmt_q[{wb_adr_i[3:2], 2'(i)}] <= wb_dat_i[8*i +: 8];
        end
      end
    end
  end

  // Key flags, write one to clear, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keys_q <= 6'h00;
      key_pulse <= 6'h00;
    end else begin
      key_pulse <= key_set;
      if (wr && wb_adr_i == `RDL_REG_KEYS && wb_sel_i[0]) begin
        keys_q <= (keys_q & ~wb_dat_i[5:0]) | key_set;
      end else begin
        keys_q <= keys_q | key_set;
      end
    end
  end

  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  rdl_pkg::rdl_tx_t st_q;
  rdl_pkg::rdl_mode_t fmode_q;
  rdl_pkg::rdl_mode_t mode;
  logic [31:0] tick_q;
  logic req_q;
  logic [4:0] idx_q;
  logic [4:0] len;
  logic [7:0] byte_d;
  logic [23:0] wsh;
  logic [63:0] ash;
  logic annun;

  assign mode = rdl_pkg::rdl_mode_t'(ctrl_q[2:0]);
  assign busy = st_q != rdl_pkg::RDL_TX_IDLE;
  assign annun = fmode_q == rdl_pkg::RDL_ANN ||
    fmode_q == rdl_pkg::RDL_KEY_ANN;

  // Update period timer and pending frame request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_q <= 32'h0000_0000;
      req_q <= 1'b0;
    end else begin
      if (tick_q >= period_q - 32'h1) begin
        tick_q <= 32'h0000_0000;
        req_q <= mode != rdl_pkg::RDL_OFF && mode <= rdl_pkg::RDL_CUSTOM;
      end else begin
        tick_q <= tick_q + 32'h1;
        if (st_q == rdl_pkg::RDL_TX_IDLE) begin
          req_q <= 1'b0;
        end
      end
    end
  end

  // Frame length per mode
  always_comb begin
    case (fmode_q)
      rdl_pkg::RDL_CUSTOM: len = {1'b0, ctrl_q[11:8]} + 5'h1;
      rdl_pkg::RDL_ANN, rdl_pkg::RDL_KEY_ANN: len = `RDL_LEN_ANN;
      default: len = `RDL_LEN_PLAIN;
    endcase
  end

  // Byte at the current frame position
  always_comb begin
    wsh = weight_q << {3'(idx_q - `RDL_IX_DIG), 2'h0};
    ash = ann_q >> {3'(idx_q - `RDL_IX_ANN), 3'h0};
    if (fmode_q == rdl_pkg::RDL_CUSTOM) begin
      byte_d = fmt_q[idx_q[3:0]];
    end else if (idx_q == 5'h00) begin
      byte_d = ctrl_q[`RDL_CTRL_NET] ? `RDL_CH_N : `RDL_CH_G;
    end else if (idx_q == `RDL_IX_SP1 || idx_q == `RDL_IX_SP2) begin
      byte_d = `RDL_CH_SP;
    end else if (idx_q < `RDL_IX_SP2) begin
      byte_d = `RDL_CH_0 | {4'h0, wsh[23:20]};
    end else if (idx_q < `RDL_IX_CR1) begin
      byte_d = idx_q == `RDL_IX_UNIT ? unit_q[15:8] : unit_q[7:0];
    end else if (idx_q == `RDL_IX_CR1) begin
      byte_d = `RDL_CH_CR;
    end else if (annun && idx_q < `RDL_IX_CR2) begin
      byte_d = ash[7:0];
    end else if (annun && idx_q == `RDL_IX_CR2) begin
      byte_d = `RDL_CH_CR;
    end else begin
      byte_d = `RDL_CH_LF;
    end
  end

  // Byte sequencer onto the link
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= rdl_pkg::RDL_TX_IDLE;
      fmode_q <= rdl_pkg::RDL_OFF;
      idx_q <= 5'h00;
      link.h2r_valid <= 1'b0;
      link.h2r_data <= 8'h00;
    end else begin
      case (st_q)
        rdl_pkg::RDL_TX_IDLE: begin
          idx_q <= 5'h00;
          if (req_q) begin
            fmode_q <= mode;
            st_q <= rdl_pkg::RDL_TX_LOAD;
          end
        end
        rdl_pkg::RDL_TX_LOAD: begin
          link.h2r_data <= byte_d;
          link.h2r_valid <= 1'b1;
          st_q <= rdl_pkg::RDL_TX_SEND;
        end
        rdl_pkg::RDL_TX_SEND: begin
          if (link.h2r_ready) begin
            link.h2r_valid <= 1'b0;
            idx_q <= idx_q + 5'h1;
            st_q <= idx_q + 5'h1 == len ? rdl_pkg::RDL_TX_IDLE :
              rdl_pkg::RDL_TX_LOAD;
          end
        end
        default: st_q <= rdl_pkg::RDL_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Key command receiver
  // ----------------------------------------
  logic pend_q;
  logic [5:0] pend_k_q;
  logic [5:0] hit;
  logic keypad;
  localparam logic [47:0] KEYS = `RDL_KEYS;

  assign keypad = mode == rdl_pkg::RDL_KEY || mode == rdl_pkg::RDL_KEY_ANN;

  // Letter match against the key table
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      hit[i] = link.r2h_data == KEYS[8*i +: 8];
    end
    key_set = 6'h00;
    if (link.r2h_valid && link.r2h_ready && keypad && pend_q &&
        link.r2h_data == `RDL_CH_LF) begin
      key_set = pend_k_q;
    end
  end

  // Letter then line feed makes one command
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_k_q <= 6'h00;
      link.r2h_ready <= 1'b0;
    end else begin
      link.r2h_ready <= 1'b1;
      if (link.r2h_valid && link.r2h_ready) begin
        pend_q <= keypad && |hit;
        pend_k_q <= hit;
      end
    end
  end
endmodule : rdl_host

// ==== rdl_link_if.sv ====
`timescale 1ns/100ps
interface rdl_link_if;
  logic [7:0] h2r_data;
  logic h2r_valid;
  logic h2r_ready;
  logic [7:0] r2h_data;
  logic r2h_valid;
  logic r2h_ready;
  modport host_end (output h2r_data, h2r_valid, r2h_ready,
    input h2r_ready, r2h_data, r2h_valid);
  modport remote_end (input h2r_data, h2r_valid, r2h_ready,
    output h2r_ready, r2h_data, r2h_valid);
endinterface : rdl_link_if

// ==== rdl_link_properties.sv ====
`timescale 1ns/100ps
`include "rdl_defines.svh"
module rdl_link_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] h2r_data,
  input wire logic h2r_valid,
  input wire logic h2r_ready,
  input wire logic [7:0] r2h_data,
  input wire logic r2h_valid,
  input wire logic r2h_ready
);
  localparam logic [63:0] ANN_USED = `RDL_ANN_MASK;
  logic [4:0] pos_q;
  logic [4:0] pos_d;
  logic [2:0] ann_ix;
  logic [7:0] used_m;
  logic h2r_take;
  logic r2h_take;
  logic plain_end;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Frame position tracking
  // ----------------------------------------------------------------
  // Accepted bytes on both directions
  assign h2r_take = h2r_valid && h2r_ready;
  assign r2h_take = r2h_valid && r2h_ready;
  assign plain_end = pos_q == 5'h0C && h2r_data == 8'h0A;
  assign ann_ix = 3'(pos_q - 5'h0C);
  assign used_m = ANN_USED[8 * ann_ix +: 8];
  // Next position, wraps after either frame length
  always_comb begin
    pos_d = pos_q + 5'h01;
    if (plain_end || pos_q == 5'h15) begin
      pos_d = 5'h00;
    end
  end
  // Position register, moves on each accepted host-to-remote byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= 5'h00;
    end else if (h2r_take) begin
      pos_q <= pos_d;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_frame_open_gn: assert property (
    h2r_take && pos_q == 5'h00 |-> h2r_data inside {8'h47, 8'h4E})
    else $error("frame does not open with G or N");
  a_space_fields: assert property (
    h2r_take && (pos_q == 5'h01 || pos_q == 5'h08) |-> h2r_data == 8'h20)
    else $error("space missing around weight");
  a_unit_then_cr: assert property (
    h2r_take && pos_q == 5'h0B |-> h2r_data == 8'h0D)
    else $error("carriage return missing after unit");
  a_tail_cr: assert property (
    h2r_take && pos_q == 5'h14 |-> h2r_data == 8'h0D)
    else $error("closing carriage return missing");
  a_tail_lf: assert property (
    h2r_take && pos_q == 5'h15 |-> h2r_data == 8'h0A)
    else $error("closing line feed missing");
  a_unused_zero: assert property (
    h2r_take && pos_q inside {[5'h0C:5'h13]} && !plain_end
    |-> (h2r_data & ~used_m) == 8'h00)
    else $error("unused annunciator bit sent high");
  a_key_letter: assert property (
    r2h_take && r2h_data != 8'h0A
    |-> r2h_data inside {8'h5A, 8'h53, 8'h54, 8'h50, 8'h55, 8'h46})
    else $error("unknown key letter");
  a_key_then_lf: assert property (
    r2h_take && r2h_data != 8'h0A |=> ##[0:3] (r2h_take && r2h_data == 8'h0A))
    else $error("key letter not followed by line feed");
  c_plain_end: cover property (h2r_take && plain_end);
  c_ann_end: cover property (h2r_take && pos_q == 5'h15);
  c_key_sent: cover property (r2h_take && r2h_data != 8'h0A);
endmodule : rdl_link_properties

// ==== rdl_pkg.sv ====
package rdl_pkg;
  typedef enum logic [2:0] {
    RDL_OFF = 3'h0, RDL_PLAIN = 3'h1, RDL_ANN = 3'h2,
    RDL_KEY = 3'h3, RDL_KEY_ANN = 3'h4, RDL_CUSTOM = 3'h5
  } rdl_mode_t;
  typedef enum logic [1:0] {
    RDL_TX_IDLE = 2'h0, RDL_TX_LOAD = 2'h1, RDL_TX_SEND = 2'h3
  } rdl_tx_t;
  typedef enum logic [1:0] {
    RDL_RX_FIELD = 2'h0, RDL_RX_DROP = 2'h1
  } rdl_rx_t;
endpackage : rdl_pkg

// ==== rdl_remote.sv ====
`timescale 1ns/100ps
`include "rdl_defines.svh"
module rdl_remote #(
  parameter logic [31:0] TMO_CYC = 32'(`RDL_TMO_CYC)
) (
  input wire logic clock,
  input wire logic rst,
  input wire rdl_pkg::rdl_mode_t mode,
  input wire logic [5:0] key_press,
  output logic show_net,
  output logic [47:0] digits,
  output logic [15:0] unit,
  output logic [63:0] ann,
  output logic lamp_net,
  output logic lamp_gross,
  output logic lamp_print,
  output logic lamp_tare,
  output logic lamp_peak,
  output logic lamp_count,
  output logic dashes,
  rdl_link_if.remote_end link
);
  // ----------------------------------------
  // Frame parser
  // ----------------------------------------
  rdl_pkg::rdl_rx_t st_q;
  logic [4:0] idx_q;
  logic sh_net_q;
  logic [47:0] sh_dig_q;
  logic [15:0] sh_unit_q;
  logic [63:0] sh_ann_q;
  logic [7:0] b;
  logic take;
  logic annun;
  logic keypad;
  logic ok;
  logic commit;
  logic [31:0] cnt_q;

  assign b = link.h2r_data;
  assign take = link.h2r_valid & link.h2r_ready;
  assign annun = mode == rdl_pkg::RDL_ANN || mode == rdl_pkg::RDL_KEY_ANN;
  assign keypad = mode == rdl_pkg::RDL_KEY || mode == rdl_pkg::RDL_KEY_ANN;

  // Expected byte check per position
  always_comb begin
    ok = 1'b1;
    commit = 1'b0;
    if (idx_q == 5'h00) begin
      ok = b == `RDL_CH_G || b == `RDL_CH_N;
    end else if (idx_q == `RDL_IX_SP1 || idx_q == `RDL_IX_SP2) begin
      ok = b == `RDL_CH_SP;
    end else if (idx_q == `RDL_IX_CR1) begin
      ok = b == `RDL_CH_CR;
    end else if (!annun && idx_q == `RDL_IX_ANN) begin
      ok = b == `RDL_CH_LF;
      commit = ok;
    end else if (idx_q == `RDL_IX_CR2) begin
      ok = b == `RDL_CH_CR;
    end else if (idx_q > `RDL_IX_CR2) begin
      ok = b == `RDL_CH_LF;
      commit = ok;
    end
  end

  // Position tracking and resync on line feed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= rdl_pkg::RDL_RX_DROP;
      idx_q <= 5'h00;
      link.h2r_ready <= 1'b0;
    end else begin
      link.h2r_ready <= 1'b1;
      if (take) begin
        case (st_q)
          rdl_pkg::RDL_RX_FIELD: begin
            if (commit) begin
              idx_q <= 5'h00;
            end else if (ok) begin
              idx_q <= idx_q + 5'h1;
            end else begin
              idx_q <= 5'h00;
              st_q <= b == `RDL_CH_LF ? rdl_pkg::RDL_RX_FIELD :
                rdl_pkg::RDL_RX_DROP;
            end
          end
          rdl_pkg::RDL_RX_DROP: begin
            if (b == `RDL_CH_LF) begin
              st_q <= rdl_pkg::RDL_RX_FIELD;
            end
          end
          default: st_q <= rdl_pkg::RDL_RX_DROP;
        endcase
      end
    end
  end

  // Shadow fields filled while parsing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_net_q <= 1'b0;
      sh_dig_q <= 48'h0000_0000_0000;
      sh_unit_q <= 16'h0000;
      sh_ann_q <= 64'h0000_0000_0000_0000;
    end else if (take && st_q == rdl_pkg::RDL_RX_FIELD) begin
      if (idx_q == 5'h00) begin
        sh_net_q <= b == `RDL_CH_N;
      end else if (idx_q < `RDL_IX_SP2 && idx_q > `RDL_IX_SP1) begin
        sh_dig_q <= {sh_dig_q[39:0], b};
      end else if (idx_q > `RDL_IX_SP2 && idx_q < `RDL_IX_CR1) begin
        sh_unit_q <= {sh_unit_q[7:0], b};
      end else if (idx_q >= `RDL_IX_ANN && idx_q < `RDL_IX_CR2) begin
        sh_ann_q <= {b, sh_ann_q[63:8]};
      end
    end
  end

  // Displayed values change only on a whole frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      show_net <= 1'b0;
      digits <= 48'h0000_0000_0000;
      unit <= 16'h0000;
      ann <= 64'h0000_0000_0000_0000;
    end else if (take && st_q == rdl_pkg::RDL_RX_FIELD && commit) begin
      show_net <= sh_net_q;
      digits <= sh_dig_q;
      unit <= sh_unit_q;
      ann <= annun ? sh_ann_q & `RDL_ANN_MASK : 64'h0;
    end
  end

  // Lamp decode from annunciator bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lamp_net <= 1'b0;
      lamp_gross <= 1'b0;
      lamp_print <= 1'b0;
      lamp_tare <= 1'b0;
      lamp_peak <= 1'b0;
      lamp_count <= 1'b0;
    end else begin
      lamp_net <= ann[15] & ann[14];
      lamp_gross <= ann[13] & ann[12];
      lamp_print <= ann[20] & ann[19];
      lamp_tare <= ann[18] & ann[17];
      lamp_peak <= ann[39] & |{ann[36], ann[34], ann[33]};
      lamp_count <= ann[39] & ~|{ann[36], ann[34], ann[33]};
    end
  end

  // Loss of frames shows dashes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
      dashes <= 1'b1;
    end else if (take && st_q == rdl_pkg::RDL_RX_FIELD && commit) begin
      cnt_q <= 32'h0000_0000;
      dashes <= 1'b0;
    end else if (cnt_q >= TMO_CYC - 32'h1) begin
      dashes <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Key command sender
  // ----------------------------------------
  localparam logic [47:0] KEYS = `RDL_KEYS;
  logic [1:0] kst_q;
  logic [7:0] letter;
  logic [11:0] kp_q;

  // Key pins through two flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kp_q <= 12'h000;
    end else begin
      kp_q <= {kp_q[5:0], key_press};
    end
  end

  // Lowest pressed key wins
  always_comb begin
    letter = 8'h00;
    for (int i = 5; i >= 0; i--) begin
      if (kp_q[6 + i]) begin
        letter = KEYS[8*i +: 8];
      end
    end
  end

  // Letter then line feed, keypad modes only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kst_q <= 2'h0;
      link.r2h_valid <= 1'b0;
      link.r2h_data <= 8'h00;
    end else begin
      case (kst_q)
        2'h0: begin
          if (keypad && |kp_q[11:6]) begin
            link.r2h_data <= letter;
            link.r2h_valid <= 1'b1;
            kst_q <= 2'h1;
          end
        end
        2'h1: begin
          if (link.r2h_ready) begin
            link.r2h_data <= `RDL_CH_LF;
            kst_q <= 2'h3;
          end
        end
        2'h3: begin
          if (link.r2h_ready) begin
            link.r2h_valid <= 1'b0;
            kst_q <= 2'h0;
          end
        end
        default: kst_q <= 2'h0;
      endcase
    end
  end
endmodule : rdl_remote

// ==== tb.sv ====
`timescale 1ns/100ps
`include "rdl_defines.svh"
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [5:0] key_pulse;
  logic [5:0] key_press = 6'h00;
  rdl_pkg::rdl_mode_t rmt_mode = rdl_pkg::RDL_OFF;
  logic show_net, lamp_net, lamp_gross, lamp_print, lamp_tare;
  logic lamp_peak, lamp_count, dashes;
  logic [47:0] digits;
  logic [15:0] unit;
  logic [63:0] ann;
  logic [7:0] h2r_q[$];
  logic [7:0] r2h_q[$];
  logic [5:0] kp_q[$];
  logic [7:0] hd[$];
  int n_errors = 0;
  int check_count = 0;
  rdl_link_if link ();
  rdl_host u_rdl_host (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .key_pulse(key_pulse), .link(link));
  rdl_remote #(.TMO_CYC(32'h0000_00C8)) u_rdl_remote (.clock(clock),
    .rst(rst), .mode(rmt_mode), .key_press(key_press),
    .show_net(show_net), .digits(digits), .unit(unit), .ann(ann),
    .lamp_net(lamp_net), .lamp_gross(lamp_gross), .lamp_print(lamp_print),
    .lamp_tare(lamp_tare), .lamp_peak(lamp_peak), .lamp_count(lamp_count),
    .dashes(dashes), .link(link));
  rdl_link_properties u_rdl_link_properties (.clock(clock), .rst(rst),
    .h2r_data(link.h2r_data), .h2r_valid(link.h2r_valid),
    .h2r_ready(link.h2r_ready), .r2h_data(link.r2h_data),
    .r2h_valid(link.r2h_valid), .r2h_ready(link.r2h_ready));
  // ----------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------
  // Clock at 125 MHz
  always #4 clock = ~clock;
  // Record accepted link bytes and host key pulses
  always @(posedge clock) begin
    if (link.h2r_valid === 1'b1 && link.h2r_ready === 1'b1) begin
      h2r_q.push_back(link.h2r_data);
    end
    if (link.r2h_valid === 1'b1 && link.r2h_ready === 1'b1) begin
      r2h_q.push_back(link.r2h_data);
    end
    if (key_pulse !== 6'h00) begin
      kp_q.push_back(key_pulse);
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk_vec(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk_vec
  // Classic Wishbone single cycle, waits for ack
  task automatic wb_io(input logic we, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    q = wb_rdat;
    if (wb_ack !== 1'b1) begin
      $display("[ERR] wb ack expected 1 seen %b", wb_ack);
      n_errors++;
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask : wb_io
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_io(1'b0, a, 32'h0, q);
    chk_vec("register read", {32'h0, e}, {32'h0, q});
  endtask : rd_chk
  // Find a whole frame after a line feed and compare it byte by byte
  task automatic chk_frame(input logic [7:0] e[$]);
    int i;
    int n;
    n = 0;
    h2r_q = {};
    while (h2r_q.size() < 3 * e.size() && n < 3000) begin
      @(posedge clock);
      n++;
    end
    i = 1;
    while (i < e.size() && !(h2r_q[i-1] === 8'h0A && h2r_q[i] === e[0])) i++;
    for (int k = 0; k < e.size(); k++) begin
      chk_vec("frame byte", {56'h0, e[k]}, {56'h0, h2r_q[i+k]});
    end
    repeat (4) @(posedge clock);
  endtask : chk_frame
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`RDL_REG_PERIOD, 32'h0013_12D0);
    rd_chk(`RDL_REG_CTRL, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
  endtask : t_regs
  task automatic t_plain(input logic net);
    hd = {net ? 8'h4E : 8'h47, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
      8'h35, 8'h20, 8'h6C, 8'h6C, 8'h0D};
    rmt_mode <= rdl_pkg::RDL_PLAIN;
    wr(`RDL_REG_CTRL, {27'h0, net, 4'h1});
    chk_frame({hd, 8'h0A});
    chk_vec("digits", {16'h0, 48'h3031_3233_3435}, {16'h0, digits});
    chk_vec("unit", 64'h6C6C, {48'h0, unit});
    chk_vec("net shown", {63'h0, net}, {63'h0, show_net});
    chk_vec("plain ann", 64'h0, ann);
    chk_vec("dashes", 64'h0, {63'h0, dashes});
  endtask : t_plain
  task automatic t_ann();
    wr(`RDL_REG_ANN_LO, 32'hFFFF_FFFF);
    wr(`RDL_REG_ANN_HI, 32'hFFFF_FFFF);
    rd_chk(`RDL_REG_ANN_LO, 32'h41FF_FF81);
    rd_chk(`RDL_REG_ANN_HI, 32'h7E7E_0197);
    rmt_mode <= rdl_pkg::RDL_ANN;
    wr(`RDL_REG_CTRL, 32'h12);
    chk_frame({hd, 8'h81, 8'hFF, 8'hFF, 8'h41, 8'h97, 8'h01, 8'h7E,
      8'h7E, 8'h0D, 8'h0A});
    chk_vec("ann", 64'h7E7E_0197_41FF_FF81, ann);
    chk_vec("lamps", 64'h3E, {lamp_net, lamp_gross, lamp_print, lamp_tare,
      lamp_peak, lamp_count});
    wr(`RDL_REG_ANN_LO, 32'h0000_4000);
    wr(`RDL_REG_ANN_HI, 32'h0000_0080);
    chk_frame({hd, 8'h00, 8'h40, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
      8'h00, 8'h0D, 8'h0A});
    chk_vec("half lamps", 64'h01, {lamp_net, lamp_gross, lamp_print,
      lamp_tare, lamp_peak, lamp_count});
  endtask : t_ann
  // One press; expect nb bytes, letter and LF when two, and the host pulse if host mode ok
  task automatic press(input int k, input int nb, input logic [5:0] kp);
    logic [7:0] keyl[6];
    int n;
    keyl = '{8'h5A, 8'h53, 8'h54, 8'h50, 8'h55, 8'h46};
    n = 0;
    r2h_q = {};
    kp_q = {};
    key_press <= 6'h01 << k;
    @(posedge clock);
    key_press <= 6'h00;
    while (r2h_q.size() < nb && n < 40) begin
      @(posedge clock);
      n++;
    end
    repeat (20) @(posedge clock);
    chk_vec("key bytes", 64'(nb), 64'(r2h_q.size()));
    if (nb == 2) begin
      chk_vec("key letter", {56'h0, keyl[k]}, {56'h0, r2h_q[0]});
      chk_vec("key lf", 64'h0A, {56'h0, r2h_q[1]});
    end
    chk_vec("key pulse", {58'h0, kp}, {58'h0, kp_q.size() > 0 ? kp_q[0]
      : 6'h00});
  endtask : press
  task automatic t_keys();
    rmt_mode <= rdl_pkg::RDL_KEY;
    wr(`RDL_REG_CTRL, 32'h03);
    for (int k = 0; k < 6; k++) begin
      press(k, 2, 6'h01 << k);
      rd_chk(`RDL_REG_KEYS, 32'(6'h01 << k));
      wr(`RDL_REG_KEYS, 32'(6'h01 << k));
    end
    rd_chk(`RDL_REG_KEYS, 32'h0);
    wr(`RDL_REG_CTRL, 32'h01);
    press(2, 2, 6'h00);
    rmt_mode <= rdl_pkg::RDL_PLAIN;
    press(0, 0, 6'h00);
  endtask : t_keys
  task automatic t_tmo();
    wr(`RDL_REG_CTRL, 32'h00);
    repeat (400) @(posedge clock);
    chk_vec("dashes on", 64'h1, {63'h0, dashes});
    rmt_mode <= rdl_pkg::RDL_KEY_ANN;
    wr(`RDL_REG_CTRL, 32'h04);
    repeat (300) @(posedge clock);
    chk_vec("dashes off", 64'h0, {63'h0, dashes});
  endtask : t_tmo
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    wr(`RDL_REG_WEIGHT, 32'h0001_2345);
    wr(`RDL_REG_UNIT, 32'h0000_6C6C);
    wr(`RDL_REG_PERIOD, 32'h0000_003C);
    t_plain(1'b0);
    t_plain(1'b1);
    t_ann();
    t_keys();
    t_tmo();
    close_out();
  end
  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    close_out();
  end
endmodule : tb
